// ---- common/arith_cfg.svh ----
// Constants for the engine variable arithmetic datapath.
// Assumes inclusion by bare name; holds definitions only.
`ifndef ARITH_CFG_SVH
`define ARITH_CFG_SVH

// ----------------------------------------------------------------
// Widths and counts
// ----------------------------------------------------------------
`define VAR_W 8
`define NUM_ENG 3
`define ENG_W 2
`define SEL_W 2
`define CNT_W 16
`define AXI_AW 12
`define AXI_DW 32
`define ADDR_LSB 2
`define ENG_LIMIT 2'h3

// ----------------------------------------------------------------
// Operand and target codes
// ----------------------------------------------------------------
`define TGT_A 2'h0
`define TGT_B 2'h1
`define TGT_C 2'h2
`define SEL_D 2'h3
`define FORM_IMM 1'h0
`define FORM_VAR 1'h1

// ----------------------------------------------------------------
// Register map (byte addresses); D sources sit at index times four
// ----------------------------------------------------------------
`define IDX_D_VAR 12'h03C
`define IDX_D_VAL 12'h042
`define ADDR_D_VAR (`IDX_D_VAR << `ADDR_LSB)
`define ADDR_D_VAL (`IDX_D_VAL << `ADDR_LSB)
`define ADDR_CTRL 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_VAR_AB0 12'h010
`define ADDR_STRIDE 12'h004
`define ADDR_VAR_C 12'h020
`define ADDR_LAST 12'h024
`define ADDR_OP_CNT 12'h028

// ----------------------------------------------------------------
// Field positions, reset values and responses
// ----------------------------------------------------------------
`define CTRL_DSEL_BIT 0
`define CTRL_CLR_BIT 1
`define STAT_REJ_BIT 0
`define AB_B_LSB 8
`define LAST_TGT_LSB 8
`define LAST_ENG_LSB 10
`define RST_VAR 8'h00
`define RST_BIT 1'h0
`define RST_CNT 16'h0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- common/arith_pkg.sv ----
// Types shared by the arithmetic datapath files.
// Assumes arith_cfg.svh is on the include path.
`include "arith_cfg.svh"

package arith_pkg;

   // One engine variable, wraps modulo 256
   typedef logic [`VAR_W-1:0] var_t;

   // Decoded instruction kind; the last value is refused
   typedef enum logic [1:0] {KIND_LOAD, KIND_ADD, KIND_SUB, KIND_NONE} op_kind_t;

endpackage : arith_pkg

// ---- common/alu_if.sv ----
// Carrier between the datapath core and its operand/ALU unit.
// Assumes both ends run on the same clock; the unit is combinational.
`include "arith_cfg.svh"

interface alu_if;
   import arith_pkg::*;

   op_kind_t kind;
   logic form;
   logic [`SEL_W-1:0] sel1;
   logic [`SEL_W-1:0] sel2;
   var_t imm;
   var_t tgt_val;
   var_t var_a;
   var_t var_b;
   var_t var_c;
   var_t var_d;
   var_t result;

   modport core (output kind, form, sel1, sel2, imm, tgt_val, var_a, var_b, var_c,
      var_d, input result);
   modport alu (input kind, form, sel1, sel2, imm, tgt_val, var_a, var_b, var_c,
      var_d, output result);

endinterface : alu_if

// ---- core/var_alu.sv ----
// Operand selection and modulo-256 add/subtract/load unit.
// Assumes the core drives all interface inputs from the same clock.
`include "arith_cfg.svh"

module var_alu
   import arith_pkg::*;
(
   alu_if.alu port
);

   // ----------------------------------------------------------------
   // Operand selection
   // ----------------------------------------------------------------
   function automatic var_t pick(input logic [`SEL_W-1:0] s, input var_t a,
      input var_t b, input var_t c, input var_t d);
      var_t v;
      v = d;
      if (s == `TGT_A) v = a;
      else if (s == `TGT_B) v = b;
      else if (s == `TGT_C) v = c;
      return v;
   endfunction : pick

   // Selected operands, codes 0..3 give A, B, C or the D source
   wire var_t op1 = pick(port.sel1, port.var_a, port.var_b, port.var_c, port.var_d);
   wire var_t op2 = pick(port.sel2, port.var_a, port.var_b, port.var_c, port.var_d);

   // Immediate form works on the target, variable form on the selections
   wire imm_form = (port.form == `FORM_IMM);
   wire var_t lhs = imm_form ? port.tgt_val : op1;
   wire var_t rhs = imm_form ? port.imm : op2;

   // ----------------------------------------------------------------
   // Arithmetic, eight bits wide so carry and borrow fall away
   // ----------------------------------------------------------------
   wire var_t sum = lhs + rhs;
   wire var_t diff = lhs - rhs;

   // Result by kind; load takes the immediate and replaces the target
   assign port.result = (port.kind == KIND_LOAD) ? port.imm :
      (port.kind == KIND_ADD) ? sum :
      (port.kind == KIND_SUB) ? diff : port.tgt_val;

endmodule : var_alu

// ---- core/engine_variable_arithmetic.sv ----
// Variable store and arithmetic datapath for the execution engines,
// with an AXI4-Lite register slave.
// Assumes the decoder drives op_* from aclk logic, one op per pulse.
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`include "arith_cfg.svh"

// Notes on behaviour
// - each engine has A and B, C shared
// - load writes immediate, replacing old value
// - target code 0 A, 1 B, 2 C
// - immediate add: target plus operand into target
// - variable add: selection one plus two
// - addition wraps modulo 256, no carry
// - immediate subtract: target minus operand
// - variable subtract: selection one minus two
// - subtraction wraps modulo 256, no borrow
// - selector codes A, B, C, D source
module engine_variable_arithmetic
   import arith_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   // Decoded instruction from the engine sequencer
   input wire logic op_valid,
   input wire logic [`ENG_W-1:0] op_engine,
   input wire logic [1:0] op_kind,
   input wire logic op_form,
   input wire logic [`SEL_W-1:0] op_target,
   input wire logic [`SEL_W-1:0] op_sel1,
   input wire logic [`SEL_W-1:0] op_sel2,
   input wire logic [`VAR_W-1:0] op_imm,
   output logic op_done,
   output logic op_reject,
   output logic [`VAR_W-1:0] op_result,
   output logic [`NUM_ENG*`VAR_W-1:0] var_a_out,
   output logic [`NUM_ENG*`VAR_W-1:0] var_b_out,
   output logic [`VAR_W-1:0] var_c_out,
   // AXI4-Lite slave
   input wire logic [`AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [`AXI_DW-1:0] s_axi_wdata,
   input wire logic [`AXI_DW/8-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [`AXI_DW-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   var_t var_a_reg [`NUM_ENG];
   var_t var_b_reg [`NUM_ENG];
   var_t var_c_reg;
   var_t d_var_reg;
   var_t d_val_reg;
   logic dsel_reg;
   logic rej_reg;
   logic [`CNT_W-1:0] op_cnt_reg;
   var_t last_res_reg;
   logic [`SEL_W-1:0] last_tgt_reg;
   logic [`ENG_W-1:0] last_eng_reg;
   logic done_reg;
   logic reject_reg;

   // Bus side state
   logic aw_full_reg;
   logic w_full_reg;
   logic [`AXI_AW-1:0] aw_addr_reg;
   logic [`AXI_DW-1:0] w_data_reg;
   logic [`AXI_DW/8-1:0] w_strb_reg;
   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [1:0] rresp_reg;
   logic [`AXI_DW-1:0] rdata_reg;

   // ----------------------------------------------------------------
   // Instruction checks
   // ----------------------------------------------------------------
   op_kind_t kind;
   assign kind = op_kind_t'(op_kind);

   // Only engines 0..2, targets A/B/C and known kinds are carried out
   wire eng_ok = (op_engine < `ENG_LIMIT);
   wire tgt_ok = (op_target != `SEL_D);
   wire kind_ok = (kind != KIND_NONE);
   wire accept = op_valid & eng_ok & tgt_ok & kind_ok;
   wire refuse = op_valid & ~accept;
   wire [`ENG_W-1:0] eng_idx = eng_ok ? op_engine : '0;

   // Locals of the issuing engine and the D source
   wire var_t cur_a = var_a_reg[eng_idx];
   wire var_t cur_b = var_b_reg[eng_idx];
   wire var_t cur_d = dsel_reg ? d_val_reg : d_var_reg;

   // Present value of the target variable
   wire var_t tgt_val = (op_target == `TGT_A) ? cur_a :
      (op_target == `TGT_B) ? cur_b : var_c_reg;

   // ----------------------------------------------------------------
   // Operand/ALU unit
   // ----------------------------------------------------------------
   alu_if alu_bus ();

   // Fields to the unit
   assign alu_bus.kind = kind;
   assign alu_bus.form = op_form;
   assign alu_bus.sel1 = op_sel1;
   assign alu_bus.sel2 = op_sel2;
   assign alu_bus.imm = op_imm;
   assign alu_bus.tgt_val = tgt_val;
   assign alu_bus.var_a = cur_a;
   assign alu_bus.var_b = cur_b;
   assign alu_bus.var_c = var_c_reg;
   assign alu_bus.var_d = cur_d;

   var_alu u_alu (
      .port(alu_bus.alu)
   );

   wire var_t result = alu_bus.result;

   // ----------------------------------------------------------------
   // Bus write decode
   // ----------------------------------------------------------------
   wire [`AXI_AW-1:0] wr_addr = {aw_addr_reg[`AXI_AW-1:`ADDR_LSB], `ADDR_LSB'(0)};
   logic [`NUM_ENG-1:0] ab_w_hit;
   wire wr_fire = aw_full_reg & w_full_reg & ~bvalid_reg;
   wire wr_lane0 = w_strb_reg[0];
   wire hit_w_ctrl = (wr_addr == `ADDR_CTRL);
   wire hit_w_stat = (wr_addr == `ADDR_STATUS);
   wire hit_w_dvar = (wr_addr == `ADDR_D_VAR);
   wire hit_w_dval = (wr_addr == `ADDR_D_VAL);
   wire hit_w_ro = (wr_addr == `ADDR_VAR_C) | (wr_addr == `ADDR_LAST) |
      (wr_addr == `ADDR_OP_CNT) | (|ab_w_hit);
   wire wr_ok = hit_w_ctrl | hit_w_stat | hit_w_dvar | hit_w_dval | hit_w_ro;
   wire wr_ctrl = wr_fire & hit_w_ctrl & wr_lane0;
   wire wr_stat = wr_fire & hit_w_stat & wr_lane0;
   wire wr_dvar = wr_fire & hit_w_dvar & wr_lane0;
   wire wr_dval = wr_fire & hit_w_dval & wr_lane0;

   // Self-clearing strobe that zeroes A, B and C, except a variable that an accepted op writes in the same cycle
   wire clr_vars = wr_ctrl & w_data_reg[`CTRL_CLR_BIT];
   // Write one clears the refused-op flag
   wire rej_clr = wr_stat & w_data_reg[`STAT_REJ_BIT];

   // ----------------------------------------------------------------
   // Bus read decode
   // ----------------------------------------------------------------
   wire [`AXI_AW-1:0] rd_addr = {s_axi_araddr[`AXI_AW-1:`ADDR_LSB], `ADDR_LSB'(0)};
   wire ar_take = s_axi_arvalid & arready_reg;
   logic [`NUM_ENG-1:0] ab_r_hit;
   logic [`AXI_DW-1:0] ab_or [`NUM_ENG+1];
   assign ab_or[0] = '0;

   // ----------------------------------------------------------------
   // Per-engine locals
   // ----------------------------------------------------------------
   genvar e;
   generate
      for (e = 0; e < `NUM_ENG; e++) begin : g_eng
         localparam logic [`AXI_AW-1:0] AB_ADDR = `AXI_AW'(`ADDR_VAR_AB0 + e * `ADDR_STRIDE);
         localparam logic [`ENG_W-1:0] ENG_ID = `ENG_W'(e);
         // Write enables for this engine's A and B
         wire we_a = accept & (eng_idx == ENG_ID) & (op_target == `TGT_A);
         wire we_b = accept & (eng_idx == ENG_ID) & (op_target == `TGT_B);
         wire var_t a_next = we_a ? result : (clr_vars ? `RST_VAR : var_a_reg[e]);
         wire var_t b_next = we_b ? result : (clr_vars ? `RST_VAR : var_b_reg[e]);
         // Read word: A low byte, B next byte
         wire [`AXI_DW-1:0] ab_word = {`AXI_DW'(var_b_reg[e]) << `AB_B_LSB} |
            `AXI_DW'(var_a_reg[e]);
         assign ab_w_hit[e] = (wr_addr == AB_ADDR);
         assign ab_r_hit[e] = (rd_addr == AB_ADDR);
         assign ab_or[e+1] = ab_or[e] | (ab_r_hit[e] ? ab_word : '0);
         assign var_a_out[e*`VAR_W +: `VAR_W] = var_a_reg[e];
         assign var_b_out[e*`VAR_W +: `VAR_W] = var_b_reg[e];

         // Local variable pair of one engine
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               var_a_reg[e] <= `RST_VAR;
               var_b_reg[e] <= `RST_VAR;
            end else begin
               var_a_reg[e] <= a_next;
               var_b_reg[e] <= b_next;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Shared variable and op bookkeeping
   // ----------------------------------------------------------------
   wire we_c = accept & (op_target == `TGT_C);
   wire var_t c_next = we_c ? result : (clr_vars ? `RST_VAR : var_c_reg);
   wire rej_next = refuse | (rej_reg & ~rej_clr);
   wire [`CNT_W-1:0] cnt_next = accept ? op_cnt_reg + `CNT_W'(1) : op_cnt_reg;

   // Shared C, written by any engine
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         var_c_reg <= `RST_VAR;
      end else begin
         var_c_reg <= c_next;
      end
   end

   // Completion pulses and last result
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         done_reg <= `RST_BIT;
         reject_reg <= `RST_BIT;
         rej_reg <= `RST_BIT;
         op_cnt_reg <= `RST_CNT;
         last_res_reg <= `RST_VAR;
         last_tgt_reg <= '0;
         last_eng_reg <= '0;
      end else begin
         done_reg <= accept;
         reject_reg <= refuse;
         rej_reg <= rej_next; // Set wins over clear
         op_cnt_reg <= cnt_next;
         if (accept) begin
            last_res_reg <= result;
            last_tgt_reg <= op_target;
            last_eng_reg <= op_engine;
         end
      end
   end

   // ----------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------
   // D sources and the select between them
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         d_var_reg <= `RST_VAR;
         d_val_reg <= `RST_VAR;
         dsel_reg <= `RST_BIT;
      end else begin
         if (wr_dvar) d_var_reg <= w_data_reg[`VAR_W-1:0];
         if (wr_dval) d_val_reg <= w_data_reg[`VAR_W-1:0];
         if (wr_ctrl) dsel_reg <= w_data_reg[`CTRL_DSEL_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Write channels
   // ----------------------------------------------------------------
   wire aw_take = s_axi_awvalid & awready_reg;
   wire w_take = s_axi_wvalid & wready_reg;
   wire b_done = bvalid_reg & s_axi_bready;
   wire aw_full_next = aw_take | (aw_full_reg & ~wr_fire);
   wire w_full_next = w_take | (w_full_reg & ~wr_fire);
   wire bvalid_next = wr_fire | (bvalid_reg & ~b_done);
   // One write at a time: ready again only once the response is gone
   wire awready_next = ~aw_full_next & ~bvalid_next;
   wire wready_next = ~w_full_next & ~bvalid_next;

   // Address and data capture, either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_reg <= `RST_BIT;
         w_full_reg <= `RST_BIT;
         aw_addr_reg <= '0;
         w_data_reg <= '0;
         w_strb_reg <= '0;
      end else begin
         aw_full_reg <= aw_full_next;
         w_full_reg <= w_full_next;
         if (aw_take) aw_addr_reg <= s_axi_awaddr;
         if (w_take) w_data_reg <= s_axi_wdata;
         if (w_take) w_strb_reg <= s_axi_wstrb;
      end
   end

   // Handshake flags and write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_reg <= `RST_BIT;
         wready_reg <= `RST_BIT;
         bvalid_reg <= `RST_BIT;
         bresp_reg <= `RESP_OKAY;
      end else begin
         awready_reg <= awready_next;
         wready_reg <= wready_next;
         bvalid_reg <= bvalid_next;
         if (wr_fire) bresp_reg <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
   end

   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   wire [`AXI_DW-1:0] word_ctrl = `AXI_DW'(dsel_reg) << `CTRL_DSEL_BIT;
   wire [`AXI_DW-1:0] word_stat = `AXI_DW'(rej_reg) << `STAT_REJ_BIT;
   wire [`AXI_DW-1:0] word_last = (`AXI_DW'(last_eng_reg) << `LAST_ENG_LSB) |
      (`AXI_DW'(last_tgt_reg) << `LAST_TGT_LSB) | `AXI_DW'(last_res_reg);
   wire hit_r_ctrl = (rd_addr == `ADDR_CTRL);
   wire hit_r_stat = (rd_addr == `ADDR_STATUS);
   wire hit_r_dvar = (rd_addr == `ADDR_D_VAR);
   wire hit_r_dval = (rd_addr == `ADDR_D_VAL);
   wire hit_r_c = (rd_addr == `ADDR_VAR_C);
   wire hit_r_last = (rd_addr == `ADDR_LAST);
   wire hit_r_cnt = (rd_addr == `ADDR_OP_CNT);
   wire rd_ok = hit_r_ctrl | hit_r_stat | hit_r_dvar | hit_r_dval | hit_r_c |
      hit_r_last | hit_r_cnt | (|ab_r_hit);

   // Read data selection; unmapped words read zero
   wire [`AXI_DW-1:0] rd_word = ab_or[`NUM_ENG] |
      (hit_r_ctrl ? word_ctrl : '0) |
      (hit_r_stat ? word_stat : '0) |
      (hit_r_dvar ? `AXI_DW'(d_var_reg) : '0) |
      (hit_r_dval ? `AXI_DW'(d_val_reg) : '0) |
      (hit_r_c ? `AXI_DW'(var_c_reg) : '0) |
      (hit_r_last ? word_last : '0) |
      (hit_r_cnt ? `AXI_DW'(op_cnt_reg) : '0);

   wire r_done = rvalid_reg & s_axi_rready;
   wire rvalid_next = ar_take | (rvalid_reg & ~r_done);

   // Read address accept and data return
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= `RST_BIT;
         rvalid_reg <= `RST_BIT;
         rresp_reg <= `RESP_OKAY;
         rdata_reg <= '0;
      end else begin
         arready_reg <= ~rvalid_next;
         rvalid_reg <= rvalid_next;
         if (ar_take) rdata_reg <= rd_word;
         if (ar_take) rresp_reg <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign op_done = done_reg;
   assign op_reject = reject_reg;
   assign op_result = last_res_reg;
   assign var_c_out = var_c_reg;
   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;

endmodule : engine_variable_arithmetic

// ---- sim/eva_props.sv ----
// Checker on the arithmetic datapath top-level ports.
// Assumes it is bound to the top module; one clock, sync reset.
`include "arith_cfg.svh"
module eva_props
   import arith_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic op_valid,
   input wire logic [`ENG_W-1:0] op_engine,
   input wire logic [1:0] op_kind,
   input wire logic op_form,
   input wire logic [`SEL_W-1:0] op_target,
   input wire logic [`SEL_W-1:0] op_sel1,
   input wire logic [`SEL_W-1:0] op_sel2,
   input wire logic [`VAR_W-1:0] op_imm,
   input wire logic op_done,
   input wire logic op_reject,
   input wire logic [`VAR_W-1:0] op_result,
   input wire logic [`NUM_ENG*`VAR_W-1:0] var_a_out,
   input wire logic [`NUM_ENG*`VAR_W-1:0] var_b_out,
   input wire logic [`VAR_W-1:0] var_c_out,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [`AXI_DW-1:0] s_axi_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Variable seen by an engine through a 2-bit code
   function automatic var_t pick(logic [1:0] e, logic [1:0] s);
      return s == 2'h0 ? var_a_out[e*8 +: 8] : s == 2'h1 ? var_b_out[e*8 +: 8] : var_c_out;
   endfunction : pick

   // Expected results from the present state
   wire acc = op_valid && op_engine != 2'h3 && op_kind != 2'h3 && op_target != 2'h3;
   wire [7:0] cur = pick(op_engine, op_target);
   wire [7:0] add_i = cur + op_imm;
   wire [7:0] sub_i = cur - op_imm;
   wire [7:0] add_v = pick(op_engine, op_sel1) + pick(op_engine, op_sel2);
   wire [7:0] sub_v = pick(op_engine, op_sel1) - pick(op_engine, op_sel2);
   wire plain = op_sel1 != 2'h3 && op_sel2 != 2'h3;
   logic [1:0] eng_q, tgt_q;

   // Remember where the last op aimed
   always_ff @(posedge aclk) begin
      eng_q <= op_engine;
      tgt_q <= op_target;
   end
   wire [7:0] slot = pick(eng_q, tgt_q);

   a_accept_done: assert property (acc |=> op_done && !op_reject)
      else $error("accepted op gave no done");
   a_refuse_bad: assert property (op_valid && !acc |=> op_reject && !op_done)
      else $error("bad code not refused");
   a_load_value: assert property (acc && op_kind == 2'h0 |=> op_result == $past(op_imm))
      else $error("load result wrong");
   a_imm_add: assert property (acc && op_kind == 2'h1 && !op_form |=> op_result == $past(add_i))
      else $error("immediate add wrong");
   a_imm_sub: assert property (acc && op_kind == 2'h2 && !op_form |=> op_result == $past(sub_i))
      else $error("immediate sub wrong");
   a_var_add: assert property (acc && op_kind == 2'h1 && op_form && plain
      |=> op_result == $past(add_v))
      else $error("variable add wrong");
   a_var_sub: assert property (acc && op_kind == 2'h2 && op_form && plain
      |=> op_result == $past(sub_v))
      else $error("variable sub wrong");
   a_target_slot: assert property (op_done |-> slot == op_result)
      else $error("result not in target");
   a_read_hold: assert property (s_axi_rvalid && s_axi_rready
      |=> !s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
endmodule : eva_props

// ---- sim/op_seq_model.sv ----
// Sequencer stand-in feeding decoded ops to the datapath.
// Assumes the bench queues ops; one op leaves per clock.
module op_seq_model (
   input wire logic aclk,
   output logic op_valid,
   output logic [1:0] op_engine,
   output logic [1:0] op_kind,
   output logic op_form,
   output logic [1:0] op_target,
   output logic [1:0] op_sel1,
   output logic [1:0] op_sel2,
   output logic [7:0] op_imm
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [18:0] q[$];

   initial {op_valid, op_engine, op_kind, op_form, op_target, op_sel1, op_sel2, op_imm} = '0;

   // Send queued ops back to back; fields churn while idle
   always @(posedge aclk) begin
      op_valid <= q.size() != 0;
      if (q.size() != 0) begin
         {op_engine, op_kind, op_form, op_target, op_sel1, op_sel2, op_imm} <= q.pop_front();
      end else begin
         {op_engine, op_kind, op_form, op_target, op_sel1, op_sel2, op_imm} <= 19'($urandom);
      end
   end
endmodule : op_seq_model

// ---- sim/engine_variable_arithmetic_tb.sv ----
// Self-checking bench for the engine arithmetic datapath.
// Assumes arith_cfg.svh on the include path and the model and checker compiled first.
`include "arith_cfg.svh"
module engine_variable_arithmetic_tb
   import arith_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, op_valid, op_form, op_done, op_reject, dsel = 0;
   logic [1:0] op_engine, op_kind, op_target, op_sel1, op_sel2, s_axi_bresp, s_axi_rresp;
   logic [7:0] op_imm, op_result, var_c_out;
   logic [23:0] var_a_out, var_b_out;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, r;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int err_total, tests_run;
   var_t va[3] = '{default: 0}, vb[3] = '{default: 0};
   var_t vc = 0, dv = 0, dl = 0;
   logic [8:0] exp_q[$];

   op_seq_model i_op_seq_model(.aclk, .op_valid, .op_engine, .op_kind, .op_form,
      .op_target, .op_sel1, .op_sel2, .op_imm);
   engine_variable_arithmetic i_engine_variable_arithmetic(.aclk, .aresetn, .op_valid,
      .op_engine, .op_kind, .op_form, .op_target, .op_sel1, .op_sel2, .op_imm, .op_done,
      .op_reject, .op_result, .var_a_out, .var_b_out, .var_c_out, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);

   // ----------------------------------------
   // Checking and bus tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t value %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_op();
      logic [8:0] e;
      e = exp_q.size() != 0 ? exp_q.pop_front() : 'x;
      tests_run++;
      if (op_reject !== e[8] || op_done !== !e[8] || (!e[8] && op_result !== e[7:0])) begin
         err_total++;
         $display("[FAIL] %0t op result %h expected %h", $time, op_result, e);
      end
   endtask : chk_op

   function automatic var_t src(logic [1:0] e, logic [1:0] s);
      return s == 0 ? va[e] : s == 1 ? vb[e] : s == 2 ? vc : (dsel ? dl : dv);
   endfunction : src

   // Note the expected outcome, then hand the op to the sequencer
   task automatic op(input logic [1:0] e, k, input logic f, input logic [1:0] t, s1, s2,
      input var_t im);
      var_t x, y, v;
      logic rej;
      rej = e == 3 || k == 3 || t == 3;
      x = f ? src(e, s1) : src(e, t);
      y = f ? src(e, s2) : im;
      v = k == 0 ? im : k == 1 ? x + y : x - y;
      if (!rej) begin
         case (t)
            0: va[e] = v;
            1: vb[e] = v;
            default: vc = v;
         endcase
      end
      exp_q.push_back({rej, v});
      i_op_seq_model.q.push_back({e, k, f, t, s1, s2, im});
   endtask : op

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (s_axi_bvalid !== 1'b1);
      chk(s_axi_bresp, 0);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] rs);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (s_axi_rvalid !== 1'b1);
      chk(s_axi_rdata, d);
      chk(s_axi_rresp, rs);
   endtask : rd

   task automatic drain();
      while (i_op_seq_model.q.size() != 0 || exp_q.size() != 0) @(posedge aclk);
   endtask : drain

   task results;
      $display("errors %0d checks %0d", err_total, tests_run);
      if (err_total == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : results

   // ----------------------------------------
   // Clock, monitor, watchdog, sequence
   // ----------------------------------------
   initial begin
      aclk = 0;
      forever #2 aclk = ~aclk;
   end

   always @(negedge aclk) if (op_done === 1'b1 || op_reject === 1'b1) chk_op();

   initial begin
      repeat (20000) @(posedge aclk);
      err_total++;
      results();
   end

   initial begin
      void'($urandom(3723));
      aresetn = 0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h05; // Readies stay up
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      rd(`ADDR_STATUS, 0, 0);
      wr(`ADDR_D_VAR, 32'h37);
      dv = 8'h37;
      wr(`ADDR_D_VAL, 32'hC8);
      dl = 8'hC8;
      op(0, 0, 0, 0, 0, 0, 8'hFA);
      op(0, 1, 0, 0, 0, 0, 8'h05);
      op(0, 1, 0, 0, 0, 0, 8'h01);
      op(0, 2, 0, 0, 0, 0, 8'h01);
      op(1, 0, 1, 2, 3, 3, 8'h11);
      op(2, 1, 1, 1, 2, 3, 8'h00);
      op(1, 2, 1, 0, 3, 0, 8'h00);
      op(3, 0, 0, 0, 0, 0, 8'h01);
      op(0, 3, 0, 0, 0, 0, 8'h02);
      op(0, 0, 0, 3, 0, 0, 8'h03);
      drain();
      rd(`ADDR_STATUS, 1, 0);
      wr(`ADDR_STATUS, 32'h1);
      rd(`ADDR_STATUS, 0, 0);
      wr(`ADDR_CTRL, 1);
      dsel = 1;
      op(0, 1, 1, 2, 3, 0, 8'h00);
      repeat (60) begin
         r = $urandom;
         op(r[1:0], r[3:2], r[4], r[6:5], r[8:7], r[10:9], r[18:11]);
      end
      drain();
      rd(`ADDR_VAR_C, {24'h0, vc}, 0);
      rd(12'h0FC, 0, `RESP_SLVERR);
      for (int e = 0; e < 3; e++) begin
         chk(var_a_out[e*8 +: 8], va[e]);
         chk(var_b_out[e*8 +: 8], vb[e]);
      end
      chk(var_c_out, vc);
      results();
   end
endmodule : engine_variable_arithmetic_tb

bind engine_variable_arithmetic eva_props i_eva_props(.aclk, .aresetn, .op_valid, .op_engine,
   .op_kind, .op_form, .op_target, .op_sel1, .op_sel2, .op_imm, .op_done, .op_reject,
   .op_result, .var_a_out, .var_b_out, .var_c_out, .s_axi_rvalid, .s_axi_rready,
   .s_axi_rdata);
